// ### core/dcs_pkg.sv
// shared constants for the debug comparator and state sequencer
package dcs_pkg;

	// ------------------------------------------------------------
	// bus and observation widths
	// ------------------------------------------------------------
	localparam int ADDR_W = 24;              // core address width
	localparam int DATA_W = 32;              // core data bus width
	localparam int AXI_AW = 8;               // register bus address width
	localparam int NCMP   = 3;               // comparators A, B, D

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [AXI_AW-1:0] OFS_CTRL_FIRST = 8'h00; // debug_control_first
	localparam logic [AXI_AW-1:0] OFS_CTRL_RANGE = 8'h04; // debug_control_range
	localparam logic [AXI_AW-1:0] OFS_STATE      = 8'h08; // sequencer state, read only
	localparam logic [AXI_AW-1:0] OFS_INT_STAT   = 8'h0C; // sticky events, read clears
	localparam logic [AXI_AW-1:0] OFS_INT_MASK   = 8'h10; // interrupt mask
	localparam logic [AXI_AW-1:0] OFS_SEQ_BASE   = 8'h14; // state 1..3 transition tables
	localparam logic [AXI_AW-1:0] OFS_CMP_BASE   = 8'h20; // comparator blocks
	localparam logic [AXI_AW-1:0] OFS_CMP_STRIDE = 8'h10; // spacing of comparator blocks
	localparam logic [AXI_AW-1:0] OFS_CMP_CTRL   = 8'h00; // within block: control
	localparam logic [AXI_AW-1:0] OFS_CMP_ADDR   = 8'h04; // within block: high/mid/low bytes
	localparam logic [AXI_AW-1:0] OFS_CMP_DATA   = 8'h08; // comparator A: data bytes 3..0
	localparam logic [AXI_AW-1:0] OFS_CMP_MASK   = 8'h0C; // comparator A: data bit mask

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int C1_ARM  = 0;              // arm / armed status
	localparam int C1_FORCE_TRIGGER_BIT = 1;              // force_trigger_bit, write one to fire
	localparam int C1_BPEN = 2;              // breakpoint enable on final state
	localparam int CC_EN   = 0;              // comparator enable
	localparam int CC_OPC  = 1;              // opcode_select
	localparam int CC_RWE  = 2;              // access_type_qualify
	localparam int CC_RW   = 3;              // direction: 1 write, 0 read
	localparam int CC_DEN  = 4;              // data compare enable (comparator A)
	localparam int CC_W    = 5;
	localparam int SEQ_W   = 12;             // four 3-bit targets per state
	localparam int TGT_W   = 3;
	localparam int INT_W   = 5;              // match A, B, D, breakpoint, disarm
	localparam int IB_BRK  = 3;
	localparam int IB_DIS  = 4;

	// ------------------------------------------------------------
	// range modes and sequencer targets
	// ------------------------------------------------------------
	localparam logic [1:0] RNG_OFF     = 2'h0; // comparators exact
	localparam logic [1:0] RNG_INSIDE  = 2'h1; // A..B inclusive on match 0
	localparam logic [1:0] RNG_OUTSIDE = 2'h2; // outside A..B on match 0
	localparam logic [TGT_W-1:0] TGT_NONE  = 3'h0;
	localparam logic [TGT_W-1:0] TGT_S1    = 3'h1;
	localparam logic [TGT_W-1:0] TGT_S2    = 3'h2;
	localparam logic [TGT_W-1:0] TGT_S3    = 3'h3;
	localparam logic [TGT_W-1:0] TGT_FINAL = 3'h4;

	// ------------------------------------------------------------
	// reset values and bus answers
	// ------------------------------------------------------------
	localparam logic [DATA_W-1:0] RST_ZERO = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// one-hot sequencer states
	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_ONE   = 5'b00010,
		ST_TWO   = 5'b00100,
		ST_THREE = 5'b01000,
		ST_FINAL = 5'b10000
	} dcs_state_e;

endpackage

// ### core/dcs_comparator.sv
// one address comparator with optional data, mask and direction qualification
`timescale 1ns/100ps
module dcs_comparator (
	// configuration
	input  wire logic [dcs_pkg::CC_W-1:0]   cfg,
	input  wire logic [dcs_pkg::ADDR_W-1:0] ref_addr,
	input  wire logic [dcs_pkg::DATA_W-1:0] ref_data,
	input  wire logic [dcs_pkg::DATA_W-1:0] ref_mask,
	// observed core buses
	input  wire logic                       exec_valid,
	input  wire logic [dcs_pkg::ADDR_W-1:0] exec_addr,
	input  wire logic                       data_valid,
	input  wire logic [dcs_pkg::ADDR_W-1:0] data_addr,
	input  wire logic [dcs_pkg::DATA_W-1:0] data_value,
	input  wire logic                       data_write,
	// results
	output logic                            qual_ok,
	output logic                            addr_eq,
	output logic                            addr_ge,
	output logic                            addr_le
);
	import dcs_pkg::*;

	logic [ADDR_W-1:0] cur_addr;
	logic              dir_ok;
	logic              data_ok;

	// opcode mode watches the execution stage only and ignores data,
	// mask and direction controls
	always_comb begin
		cur_addr = cfg[CC_OPC] ? exec_addr : data_addr;
		dir_ok   = !cfg[CC_RWE] || (data_write == cfg[CC_RW]);
		data_ok  = !cfg[CC_DEN] || (((data_value ^ ref_data) & ~ref_mask) == RST_ZERO);
		if (cfg[CC_OPC]) begin
			qual_ok = cfg[CC_EN] && exec_valid;
		end else begin
			qual_ok = cfg[CC_EN] && data_valid && dir_ok && data_ok;
		end
		addr_eq = (cur_addr == ref_addr);
		addr_ge = (cur_addr >= ref_addr);
		addr_le = (cur_addr <= ref_addr);
	end

endmodule

// ### core/dcs_top.sv
// debug monitor: three comparators, state sequencer, AXI4-Lite registers
//
// Functional notes
// - three comparators match address against opcode PC or data address bus
// - comparator A alone also compares data, with a per-bit exclusion mask
// - exact or range match; range chosen by range control register
// - with access qualify set, direction must equal the direction bit
// - opcode select matches opcode addresses only, ignoring data controls
// - opcode select clear matches data access addresses
// - opcode match flagged when opcode reaches execution stage, before execution
// - data match flagged when address, and data if enabled, equal programmed value
// - any comparator match can move the sequencer to a programmed state
// - states 1, 2 and 3 may move among each other freely
// - final state optionally raises breakpoint, then idle and disarmed
// - external event or force trigger bit also cause a transition
// - a match is an event; the original condition is never re-checked
// - match 0, 1, 3 map to comparators A, B, D except in range mode
//
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
module dcs_top (
	// clock and reset
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	// axi4-lite write address and data
	input  wire logic [dcs_pkg::AXI_AW-1:0] s_axi_awaddr,
	input  wire logic [2:0]                 s_axi_awprot,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [dcs_pkg::DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	// axi4-lite read
	input  wire logic [dcs_pkg::AXI_AW-1:0] s_axi_araddr,
	input  wire logic [2:0]                 s_axi_arprot,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [dcs_pkg::DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	// observed processor buses
	input  wire logic                       exec_valid,
	input  wire logic [dcs_pkg::ADDR_W-1:0] exec_addr,
	input  wire logic                       data_valid,
	input  wire logic [dcs_pkg::ADDR_W-1:0] data_addr,
	input  wire logic [dcs_pkg::DATA_W-1:0] data_value,
	input  wire logic                       data_write,
	// external event pin
	input  wire logic                       ext_event,
	// debug outputs
	output logic                            breakpoint,
	output logic                            armed,
	output logic                            irq
);
	import dcs_pkg::*;

	// ------------------------------------------------------------
	// decoding helpers
	// ------------------------------------------------------------
	// byte-lane merge for partial writes
	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
		input logic [DATA_W-1:0] new_v, input logic [3:0] strb);
		logic [DATA_W-1:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction

	// comparator block hit: returns 1 when offset equals register sub of block i
	function automatic logic cmp_hit(input logic [AXI_AW-1:0] a, input int i,
		input logic [AXI_AW-1:0] sub);
		return a == (OFS_CMP_BASE + OFS_CMP_STRIDE * AXI_AW'(i) + sub);
	endfunction

	// state code for a sequencer target
	function automatic dcs_state_e tgt_state(input logic [TGT_W-1:0] t);
		dcs_state_e s;
		s = ST_IDLE;
		case (t)
			TGT_S1:    s = ST_ONE;
			TGT_S2:    s = ST_TWO;
			TGT_S3:    s = ST_THREE;
			TGT_FINAL: s = ST_FINAL;
			default:   s = ST_IDLE;
		endcase
		return s;
	endfunction

	// ------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------
	logic                    bp_en_q;
	logic [1:0]              range_q;
	logic [CC_W-1:0]         cmp_cfg_q  [NCMP];
	logic [ADDR_W-1:0]       cmp_addr_q [NCMP];
	logic [DATA_W-1:0]       cmp_data_q;
	logic [DATA_W-1:0]       cmp_mask_q;
	logic [SEQ_W-1:0]        seq_tab_q  [3];
	logic [INT_W-1:0]        int_stat_q;
	logic [INT_W-1:0]        int_mask_q;
	dcs_state_e              state_q;
	dcs_state_e              state_d;

	// bus side
	logic                    aw_held_q;
	logic                    w_held_q;
	logic [AXI_AW-1:0]       awaddr_q;
	logic [DATA_W-1:0]       wdata_q;
	logic [3:0]              wstrb_q;
	logic                    wr_fire;
	logic                    rd_fire;
	logic                    wr_ctrl;
	logic                    force_trigger_bit_q;
	logic                    ext_s1_q;
	logic                    ext_s2_q;
	logic                    ext_s3_q;
	logic                    ext_pulse;
	logic [2:0]              match_q;
	logic [NCMP-1:0]         c_qual;
	logic [NCMP-1:0]         c_eq;
	logic [NCMP-1:0]         c_ge;
	logic [NCMP-1:0]         c_le;
	logic [2:0]              match_d;
	logic [DATA_W-1:0]       rd_val;
	logic                    rd_ok;
	logic [INT_W-1:0]        int_ev;

	// ------------------------------------------------------------
	// comparators A, B, D
	// ------------------------------------------------------------
	// only comparator A may compare data; the others have data compare enable cleared
	for (genvar i = 0; i < NCMP; i++) begin : g_cmp
		dcs_comparator u_cmp (
			.cfg        (i == 0 ? cmp_cfg_q[i] : (cmp_cfg_q[i] & ~(CC_W'(1) << CC_DEN))),
			.ref_addr   (cmp_addr_q[i]),
			.ref_data   (cmp_data_q),
			.ref_mask   (cmp_mask_q),
			.exec_valid (exec_valid),
			.exec_addr  (exec_addr),
			.data_valid (data_valid),
			.data_addr  (data_addr),
			.data_value (data_value),
			.data_write (data_write),
			.qual_ok    (c_qual[i]),
			.addr_eq    (c_eq[i]),
			.addr_ge    (c_ge[i]),
			.addr_le    (c_le[i])
		);
	end

	// match 0/1/3 straight from A/B/D; range modes fold A..B into match 0
	always_comb begin
		match_d[0] = c_qual[0] && c_eq[0];
		match_d[1] = c_qual[1] && c_eq[1];
		match_d[2] = c_qual[2] && c_eq[2];
		if (range_q == RNG_INSIDE) begin
			match_d[0] = c_qual[0] && c_ge[0] && c_le[1];
			match_d[1] = 1'b0;
		end else if (range_q == RNG_OUTSIDE) begin
			match_d[0] = c_qual[0] && !(c_ge[0] && c_le[1]);
			match_d[1] = 1'b0;
		end
	end

	// matches are registered as one-cycle events; nothing is re-checked later
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			match_q <= 3'h0;
		end else begin
			match_q <= match_d;
		end
	end

	// ------------------------------------------------------------
	// external event synchroniser
	// ------------------------------------------------------------
	// pin is asynchronous; rising edge taken after two flops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
		end else begin
			ext_s1_q <= ext_event;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end
	assign ext_pulse = ext_s2_q && !ext_s3_q;

	// ------------------------------------------------------------
	// state sequencer
	// ------------------------------------------------------------
	// priority: match 0, match 1, match 3, then external or forced trigger
	always_comb begin
		logic [SEQ_W-1:0] tab;
		logic [TGT_W-1:0] tgt;
		tab     = RST_ZERO[SEQ_W-1:0];
		tgt     = TGT_NONE;
		state_d = state_q;
		unique case (state_q)
			ST_ONE:   tab = seq_tab_q[0];
			ST_TWO:   tab = seq_tab_q[1];
			ST_THREE: tab = seq_tab_q[2];
			ST_IDLE, ST_FINAL: tab = RST_ZERO[SEQ_W-1:0];
		endcase
		if (match_q[0] && tab[0 +: TGT_W] != TGT_NONE) begin
			tgt = tab[0 +: TGT_W];
		end else if (match_q[1] && tab[TGT_W +: TGT_W] != TGT_NONE) begin
			tgt = tab[TGT_W +: TGT_W];
		end else if (match_q[2] && tab[2*TGT_W +: TGT_W] != TGT_NONE) begin
			tgt = tab[2*TGT_W +: TGT_W];
		end else if (force_trigger_bit_q || ext_pulse) begin
			tgt = tab[3*TGT_W +: TGT_W];
		end
		if (state_q == ST_FINAL) begin
			state_d = ST_IDLE;
		end else if (tgt != TGT_NONE && state_q != ST_IDLE) begin
			state_d = tgt_state(tgt);
		end
		// software disarm overrides the transition table; arm only moves idle to state 1
		if (wr_ctrl && wstrb_q[0]) begin
			if (!wdata_q[C1_ARM]) begin
				state_d = ST_IDLE;
			end else if (state_q == ST_IDLE) begin
				state_d = ST_ONE;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// breakpoint pulses on entry to the final state when enabled
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			breakpoint <= 1'b0;
			armed      <= 1'b0;
		end else begin
			breakpoint <= bp_en_q && state_d == ST_FINAL && state_q != ST_FINAL;
			armed      <= state_d != ST_IDLE;
		end
	end

	// ------------------------------------------------------------
	// axi4-lite write path
	// ------------------------------------------------------------
	// address and data may come in either order; the write lands once both held
	assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
	assign wr_ctrl = wr_fire && awaddr_q == OFS_CTRL_FIRST;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q     <= 1'b0;
			w_held_q      <= 1'b0;
			awaddr_q      <= '0;
			wdata_q       <= RST_ZERO;
			wstrb_q       <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddr_q == OFS_STATE || awaddr_q == OFS_INT_STAT ||
					!addr_known(awaddr_q)) ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_held_q    <= 1'b0;
				w_held_q     <= 1'b0;
			end
		end
	end

	// mapped offsets
	function automatic logic addr_known(input logic [AXI_AW-1:0] a);
		logic k;
		k = a == OFS_CTRL_FIRST || a == OFS_CTRL_RANGE || a == OFS_STATE ||
			a == OFS_INT_STAT || a == OFS_INT_MASK || cmp_hit(a, 0, OFS_CMP_DATA) ||
			cmp_hit(a, 0, OFS_CMP_MASK);
		for (int i = 0; i < 3; i++) begin
			k = k || a == OFS_SEQ_BASE + AXI_AW'(4 * i);
		end
		for (int i = 0; i < NCMP; i++) begin
			k = k || cmp_hit(a, i, OFS_CMP_CTRL) || cmp_hit(a, i, OFS_CMP_ADDR);
		end
		return k;
	endfunction

	// configuration registers; arm is held in the sequencer state itself
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bp_en_q    <= 1'b0;
			range_q    <= RNG_OFF;
			cmp_data_q <= RST_ZERO;
			cmp_mask_q <= RST_ZERO;
			int_mask_q <= '0;
			force_trigger_bit_q     <= 1'b0;
			for (int i = 0; i < NCMP; i++) begin
				cmp_cfg_q[i]  <= '0;
				cmp_addr_q[i] <= '0;
			end
			for (int i = 0; i < 3; i++) begin
				seq_tab_q[i] <= '0;
			end
		end else begin
			force_trigger_bit_q <= wr_ctrl && wstrb_q[0] && wdata_q[C1_FORCE_TRIGGER_BIT];
			if (wr_fire) begin
				if (awaddr_q == OFS_CTRL_FIRST && wstrb_q[0]) begin
					bp_en_q <= wdata_q[C1_BPEN];
				end
				if (awaddr_q == OFS_CTRL_RANGE) begin
					range_q <= 2'(merge({30'h0, range_q}, wdata_q, wstrb_q));
				end
				if (awaddr_q == OFS_INT_MASK) begin
					int_mask_q <= INT_W'(merge({27'h0, int_mask_q}, wdata_q, wstrb_q));
				end
				if (cmp_hit(awaddr_q, 0, OFS_CMP_DATA)) begin
					cmp_data_q <= merge(cmp_data_q, wdata_q, wstrb_q);
				end
				if (cmp_hit(awaddr_q, 0, OFS_CMP_MASK)) begin
					cmp_mask_q <= merge(cmp_mask_q, wdata_q, wstrb_q);
				end
				for (int i = 0; i < 3; i++) begin
					if (awaddr_q == OFS_SEQ_BASE + AXI_AW'(4 * i)) begin
						seq_tab_q[i] <= SEQ_W'(merge({20'h0, seq_tab_q[i]}, wdata_q, wstrb_q));
					end
				end
				for (int i = 0; i < NCMP; i++) begin
					if (cmp_hit(awaddr_q, i, OFS_CMP_CTRL)) begin
						cmp_cfg_q[i] <= CC_W'(merge({27'h0, cmp_cfg_q[i]}, wdata_q, wstrb_q));
					end
					if (cmp_hit(awaddr_q, i, OFS_CMP_ADDR)) begin
						cmp_addr_q[i] <= ADDR_W'(merge({8'h0, cmp_addr_q[i]}, wdata_q, wstrb_q));
					end
				end
			end
		end
	end

	// ------------------------------------------------------------
	// axi4-lite read path
	// ------------------------------------------------------------
	assign rd_fire = s_axi_arvalid && s_axi_arready;

	// read mux; unmapped offsets read zero with an error answer
	always_comb begin
		rd_val = RST_ZERO;
		rd_ok  = addr_known(s_axi_araddr);
		if (s_axi_araddr == OFS_CTRL_FIRST) begin
			rd_val[C1_ARM]  = state_q != ST_IDLE;
			rd_val[C1_BPEN] = bp_en_q;
		end
		if (s_axi_araddr == OFS_CTRL_RANGE) rd_val[1:0] = range_q;
		if (s_axi_araddr == OFS_STATE) rd_val[4:0] = state_q;
		if (s_axi_araddr == OFS_INT_STAT) rd_val[INT_W-1:0] = int_stat_q;
		if (s_axi_araddr == OFS_INT_MASK) rd_val[INT_W-1:0] = int_mask_q;
		if (cmp_hit(s_axi_araddr, 0, OFS_CMP_DATA)) rd_val = cmp_data_q;
		if (cmp_hit(s_axi_araddr, 0, OFS_CMP_MASK)) rd_val = cmp_mask_q;
		for (int i = 0; i < 3; i++) begin
			if (s_axi_araddr == OFS_SEQ_BASE + AXI_AW'(4 * i)) rd_val[SEQ_W-1:0] = seq_tab_q[i];
		end
		for (int i = 0; i < NCMP; i++) begin
			if (cmp_hit(s_axi_araddr, i, OFS_CMP_CTRL)) rd_val[CC_W-1:0] = cmp_cfg_q[i];
			if (cmp_hit(s_axi_araddr, i, OFS_CMP_ADDR)) rd_val[ADDR_W-1:0] = cmp_addr_q[i];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= RST_ZERO;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !rd_fire;
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_val;
				s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// interrupt status
	// ------------------------------------------------------------
	// a read clears, but an event in the same cycle survives the clear
	assign int_ev = {state_q == ST_FINAL, state_d == ST_FINAL && state_q != ST_FINAL, match_q};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_stat_q <= '0;
			irq        <= 1'b0;
		end else begin
			if (rd_fire && s_axi_araddr == OFS_INT_STAT) begin
				int_stat_q <= int_ev;
			end else begin
				int_stat_q <= int_stat_q | int_ev;
			end
			irq <= |(int_stat_q & int_mask_q);
		end
	end

endmodule

// ### tb/dcs_sva.sv
// port assertions for the debug monitor
`timescale 1ns/100ps
module dcs_sva (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// bus handshakes
	input wire logic        s_axi_awready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// debug outputs
	input wire logic        breakpoint,
	input wire logic        armed,
	input wire logic        irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// reset must clear outputs even though everything else is disabled then
	reset_quiet_a: assert property (disable iff (1'b0) !aresetn |=> !armed && !breakpoint && !irq)
		else $error("output active after reset");
	bp_final_a: assert property (breakpoint |-> armed ##1 (!breakpoint && !armed))
		else $error("breakpoint not followed by disarm");
	bp_armed_a: assert property (breakpoint |-> $past(armed))
		else $error("breakpoint from idle");
	arm_by_write_a: assert property ($rose(armed) |-> s_axi_bvalid)
		else $error("armed without a write");
	// bus answers
	b_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("address taken during response");
	r_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during data");
	b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("response repeated");
	r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data repeated");
	cov_bp: cover property (breakpoint);
	cov_arm: cover property ($rose(armed));
	cov_irq: cover property ($rose(irq));
endmodule

bind dcs_top dcs_sva u_sva (.aclk, .aresetn, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .breakpoint, .armed, .irq);

// ### tb/dcs_core_model.sv
// processor side: one opcode or data access cycle per call
`timescale 1ns/100ps
module dcs_core_model (
	// clock
	input wire logic aclk,
	// observed buses
	output logic        exec_valid = 1'b0,
	output logic [23:0] exec_addr = 24'h0,
	output logic        data_valid = 1'b0,
	output logic [23:0] data_addr = 24'h0,
	output logic [31:0] data_value = 32'h0,
	output logic        data_write = 1'b0
);
	// idle address and data lines show the inverse and valids drop, so a stale value can never match
	task automatic access(input logic o, input logic [23:0] a, input logic [31:0] d, input logic w);
		@(posedge aclk);
		exec_valid <= o;
		data_valid <= !o;
		exec_addr <= a;
		data_addr <= a;
		data_value <= d;
		data_write <= w;
		@(posedge aclk);
		exec_valid <= 1'b0;
		data_valid <= 1'b0;
		exec_addr <= ~a;
		data_addr <= ~a;
		data_value <= ~d;
	endtask
endmodule

// ### tb/dcs_top_tb.sv
// self-checking bench for the debug monitor
`timescale 1ns/100ps
module dcs_top_tb;
	import dcs_pkg::*;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, exec_valid, data_valid, data_write, ext_event, breakpoint;
	logic        armed, irq;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, data_value, v, dv;
	logic [23:0] exec_addr, data_addr, ra, rb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	int          err_total = 0, checked = 0, bp_cnt = 0, seed = 32'hf58b, n;
	dcs_top DUT (.*);
	dcs_core_model P (.*);
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	// breakpoint pulses counted as the model's view of sequencer completions
	always @(posedge aclk) if (breakpoint === 1'b1) bp_cnt <= bp_cnt + 1;
	function automatic logic [31:0] st(input int c);
		return 32'h1 << c;
	endfunction
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge aclk);
		#1;
	endtask
	// bounded wait on the response; a hang ends the run
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50 && !(s_axi_bvalid === 1'b1); n++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		r = s_axi_bresp; s_axi_bready <= 1'b0;
		if (n == 50) begin err_total++; results; end
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
		for (n = 0; n < 50 && !(s_axi_rvalid === 1'b1); n++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		v = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 1'b0;
		if (n == 50) begin err_total++; results; end
	endtask
	initial begin
		aresetn = 1'b0; s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0; s_axi_rready = 1'b0; ext_event = 1'b0;
		s_axi_awaddr = 8'h0; s_axi_araddr = 8'h0; s_axi_wdata = 32'h0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		ra = 24'($random(seed)); rb = 24'($random(seed)); dv = $random(seed);
		rd(OFS_STATE); chk("state", st(0), v);
		rd(8'hFC); chk("unmapped", RESP_SLVERR, r);
		// comparator A: write-qualified data match, low byte masked, state 1 goes final
		wr(8'h20, 32'h1D); wr(8'h24, ra); wr(8'h28, dv); wr(8'h2C, 32'hFF);
		wr(OFS_SEQ_BASE, TGT_FINAL); wr(OFS_INT_MASK, 32'h8); wr(OFS_CTRL_FIRST, 32'h5);
		P.access(0, ra, dv, 0); P.access(0, ra ^ 24'h1, dv, 1); P.access(0, ra, dv ^ 32'h100, 1);
		cyc(4); rd(OFS_STATE); chk("data miss", st(1), v);
		chk("no bp", 0, bp_cnt);
		P.access(0, ra, dv ^ 32'h5A, 1); cyc(4);
		chk("bp", 1, bp_cnt);
		chk("armed", 0, armed);
		chk("irq", 1, irq);
		rd(OFS_INT_STAT); chk("stat", 32'h19, v);
		rd(OFS_INT_STAT); cyc(2); chk("stat clr", 0, v);
		chk("irq clr", 0, irq);
		// comparator B in opcode mode: s1 -B-> s2 -event-> s3 -B-> final
		wr(8'h30, 32'hF); wr(8'h34, rb); wr(OFS_SEQ_BASE, 32'h10); wr(8'h18, 32'h600);
		wr(8'h1C, 32'h20); wr(OFS_CTRL_FIRST, 32'h5);
		P.access(0, rb, dv, 1); P.access(1, rb ^ 24'h2, dv, 0); cyc(4);
		rd(OFS_STATE); chk("opc miss", st(1), v);
		P.access(1, rb, dv, 0); cyc(4);
		rd(OFS_STATE); chk("opc hit", st(2), v);
		ext_event <= 1'b1; cyc(2); ext_event <= 1'b0; cyc(6);
		rd(OFS_STATE); chk("event", st(3), v);
		P.access(1, rb, dv, 0); cyc(4);
		chk("bp2", 2, bp_cnt);
		chk("armed2", 0, armed);
		// range inside A..B, then a forced trigger, then a refused write
		wr(8'h20, 32'h1); wr(8'h24, 32'h100); wr(8'h30, 32'h1); wr(8'h34, 32'h200);
		wr(OFS_CTRL_RANGE, RNG_INSIDE); wr(OFS_SEQ_BASE, TGT_FINAL); wr(OFS_CTRL_FIRST, 32'h5);
		P.access(0, 24'h280, dv, 1); cyc(4);
		chk("rng miss", 2, bp_cnt);
		P.access(0, 24'h180, dv, 0); cyc(4);
		chk("rng hit", 3, bp_cnt);
		wr(OFS_SEQ_BASE, 32'h800); wr(OFS_CTRL_FIRST, 32'h7); cyc(4);
		chk("force_trigger_bit", 4, bp_cnt);
		wr(OFS_STATE, 32'h1);
		chk("ro write", RESP_SLVERR, r);
		results;
	end
endmodule
